/* File: rtl/stk_regs.svh */
// Register map, field positions and reset values of the system tick timer
// Included by the design files; definitions only
`ifndef STK_REGS_SVH
`define STK_REGS_SVH

`define STK_OFS_CTRL        4'h0
`define STK_OFS_RELOAD      4'h4
`define STK_OFS_CURRENT     4'h8
`define STK_OFS_CALIB       4'hc
`define STK_BASE_ADDR       32'he000e010

`define STK_CS_ENABLE_BIT   0
`define STK_CS_EXC_BIT      1
`define STK_CS_SRC_BIT      2
`define STK_CS_FLAG_BIT     16
`define STK_CAL_REFABS_BIT  31

`define STK_RST_CTRL        32'h00000000
`define STK_RST_RELOAD      24'h000000
`define STK_RST_CURRENT     24'h000000
`define STK_CAL_TEN_MS      24'h002328
`define STK_REF_DIV         4'h8
`define STK_UNMAPPED_DATA   32'h00000000

`endif

/* File: rtl/stk_pkg.sv */
// Types shared by the system tick timer files
// No surroundings assumed
package stk_pkg;
   typedef logic [23:0] stk_count_t;
   typedef enum logic [2:0] {
      STK_BUS_IDLE = 3'b001,
      STK_BUS_ACK  = 3'b010,
      STK_BUS_RSV  = 3'b100
   } stk_bus_e;
endpackage

/* File: rtl/stk_ref_tick.sv */
// Reference tick divider: one-cycle enable every DIV clocks
// Assumes a single clock domain and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "stk_regs.svh"
module stk_ref_tick #(
   parameter int DIV = 8
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic run_i,
   output logic      tick_o
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;

   // Counter stops with the gated clock so the phase resumes where it was
   always_comb begin
      nxt_cnt = cnt_ff;
      if (run_i) begin
         if (cnt_ff == 4'(DIV - 1)) begin
            nxt_cnt = 4'h0;
         end else begin
            nxt_cnt = cnt_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign tick_o = run_i && (cnt_ff == 4'(DIV - 1));
endmodule
`default_nettype wire

/* File: rtl/stk_timer.sv */
// System tick timer: 24-bit periodic down-counter with Avalon-MM registers
// Assumes one 200 MHz clock, synchronous reset, word accesses from software
//
// How it works
// - 24-bit down-counter reloads after reaching zero
// - Counter holds while core is debug-halted
// - Zero flag at bit 16, cleared by read
// - Bit 2 picks divided-by-eight or full-rate tick
// - Bit 1 gates the exception request
// - Enable loads reload value, counts, flags, reloads
// - Reload register holds 24-bit start value
// - Flag and request only on 1 to 0
// - Current register reads live counter
// - Writing current register zeroes counter, and flag unless a 1 to 0 step sets it
// - Calibration bit 31 reads zero
// - Calibration low bits hold ten-millisecond count
// - Counting stops while the core clock is gated
// - Registers at offsets 0, 4, 8, 0xc
// - Reset clears control, reload and current value
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "stk_regs.svh"
module stk_timer #(
   parameter logic [23:0] TEN_MILLISECOND_COUNT_COUNT = `STK_CAL_TEN_MS,
   parameter int          REF_DIV     = 8
) (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RSTN_I,
   // Core status
   input  wire logic        DEBUG_HALT_I,
   input  wire logic        CORE_CLK_RUN_I,
   // Avalon-MM slave
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output logic [31:0]      AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   // Exception request
   output logic             TICK_EXC_REQ_O
);
   stk_pkg::stk_bus_e   bus_ff;
   stk_pkg::stk_bus_e   nxt_bus;
   logic                enable_ff;
   logic                exc_en_ff;
   logic                src_ff;
   logic                flag_ff;
   stk_pkg::stk_count_t reload_ff;
   stk_pkg::stk_count_t count_ff;
   logic [31:0]         rdata_ff;
   logic                req_ff;
   logic                nxt_enable;
   logic                nxt_exc_en;
   logic                nxt_src;
   logic                nxt_flag;
   stk_pkg::stk_count_t nxt_reload;
   stk_pkg::stk_count_t nxt_count;
   logic [31:0]         nxt_rdata;
   logic                nxt_req;
   logic                ref_tick;
   logic                tick;
   logic                hit_zero;
   logic                acc;
   logic                wr;
   logic                rd;

   stk_ref_tick #(
      .DIV     (REF_DIV)
   ) u_ref (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RSTN_I),
      .run_i   (CORE_CLK_RUN_I),
      .tick_o  (ref_tick)
   );

   // One wait cycle: request is taken in IDLE, answered in ACK
   assign acc = (AVS_READ_I || AVS_WRITE_I) && (bus_ff == stk_pkg::STK_BUS_IDLE);
   assign wr  = acc && AVS_WRITE_I;
   assign rd  = acc && AVS_READ_I;
   assign AVS_WAITREQUEST_O = !(bus_ff == stk_pkg::STK_BUS_ACK);

   always_comb begin
      case (bus_ff)
         stk_pkg::STK_BUS_IDLE: begin
            nxt_bus = acc ? stk_pkg::STK_BUS_ACK : stk_pkg::STK_BUS_IDLE;
         end
         default: begin
            nxt_bus = stk_pkg::STK_BUS_IDLE;
         end
      endcase
   end

   // Tick stalls in debug halt and while the core clock is gated
   assign tick = enable_ff && !DEBUG_HALT_I && CORE_CLK_RUN_I
                 && (src_ff ? 1'b1 : ref_tick);
   assign hit_zero = tick && (count_ff == 24'h000001);

   always_comb begin
      nxt_enable = enable_ff;
      nxt_exc_en = exc_en_ff;
      nxt_src    = src_ff;
      nxt_flag   = flag_ff;
      nxt_reload = reload_ff;
      nxt_count  = count_ff;
      nxt_rdata  = rdata_ff;
      nxt_req    = 1'b0;
      // Counter step
      if (tick) begin
         if (count_ff == 24'h000000) begin
            nxt_count = reload_ff;
         end else begin
            nxt_count = count_ff - 24'h000001;
         end
      end
      // Register writes; offsets are byte addresses
      if (wr) begin
         if (AVS_ADDRESS_I == `STK_OFS_CTRL) begin
            nxt_enable = AVS_WRITEDATA_I[`STK_CS_ENABLE_BIT];
            nxt_exc_en = AVS_WRITEDATA_I[`STK_CS_EXC_BIT];
            nxt_src    = AVS_WRITEDATA_I[`STK_CS_SRC_BIT];
            if (AVS_WRITEDATA_I[`STK_CS_ENABLE_BIT] && !enable_ff) begin
               nxt_count = reload_ff;
            end
         end else if (AVS_ADDRESS_I == `STK_OFS_RELOAD) begin
            nxt_reload = AVS_WRITEDATA_I[23:0];
         end else if (AVS_ADDRESS_I == `STK_OFS_CURRENT) begin
            nxt_count = 24'h000000;
            nxt_flag  = 1'b0;
         end
      end
      // Register reads captured in the accepting cycle
      if (rd) begin
         if (AVS_ADDRESS_I == `STK_OFS_CTRL) begin
            nxt_rdata = 32'h00000000;
            nxt_rdata[`STK_CS_FLAG_BIT]   = flag_ff;
            nxt_rdata[`STK_CS_SRC_BIT]    = src_ff;
            nxt_rdata[`STK_CS_EXC_BIT]    = exc_en_ff;
            nxt_rdata[`STK_CS_ENABLE_BIT] = enable_ff;
            nxt_flag = 1'b0;
         end else if (AVS_ADDRESS_I == `STK_OFS_RELOAD) begin
            nxt_rdata = {8'h00, reload_ff};
         end else if (AVS_ADDRESS_I == `STK_OFS_CURRENT) begin
            nxt_rdata = {8'h00, count_ff};
         end else if (AVS_ADDRESS_I == `STK_OFS_CALIB) begin
            nxt_rdata = {8'h00, TEN_MILLISECOND_COUNT_COUNT};
            nxt_rdata[`STK_CAL_REFABS_BIT] = 1'b0;
         end else begin
            nxt_rdata = `STK_UNMAPPED_DATA;
         end
      end
      // Hardware set wins over a read clear in the same cycle
      if (hit_zero) begin
         nxt_flag = 1'b1;
         nxt_req  = exc_en_ff;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         bus_ff    <= stk_pkg::STK_BUS_IDLE;
         enable_ff <= 1'b0;
         exc_en_ff <= 1'b0;
         src_ff    <= 1'b0;
         flag_ff   <= 1'b0;
         reload_ff <= `STK_RST_RELOAD;
         count_ff  <= `STK_RST_CURRENT;
         rdata_ff  <= 32'h00000000;
         req_ff    <= 1'b0;
      end else begin
         bus_ff    <= nxt_bus;
         enable_ff <= nxt_enable;
         exc_en_ff <= nxt_exc_en;
         src_ff    <= nxt_src;
         flag_ff   <= nxt_flag;
         reload_ff <= nxt_reload;
         count_ff  <= nxt_count;
         rdata_ff  <= nxt_rdata;
         req_ff    <= nxt_req;
      end
   end

   assign AVS_READDATA_O = rdata_ff;
   assign TICK_EXC_REQ_O = req_ff;
endmodule
`default_nettype wire

/* File: bench/stk_timer_props.sv */
// Checker of bus answers, readback fields and the tick request
// Bound into every stk_timer; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module stk_timer_props #(parameter logic [23:0] TEN_MILLISECOND_COUNT_COUNT = 24'h002328) (
   // Watched ports
   input wire logic        SYS_CLK_I,
   input wire logic        RSTN_I,
   input wire logic        DEBUG_HALT_I,
   input wire logic        CORE_CLK_RUN_I,
   input wire logic [3:0]  AVS_ADDRESS_I,
   input wire logic        AVS_READ_I,
   input wire logic        AVS_WRITE_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic        AVS_WAITREQUEST_O,
   input wire logic        TICK_EXC_REQ_O
);
   wire logic        wt = AVS_WAITREQUEST_O;
   wire logic        ex = TICK_EXC_REQ_O;
   wire logic [31:0] q  = AVS_READDATA_O;
   wire logic [3:0]  a  = AVS_ADDRESS_I;
   wire logic        tk = AVS_READ_I & wt;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_one; !wt |=> wt; endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_ans; (AVS_READ_I || AVS_WRITE_I) && wt |=> !wt; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_cal; tk && a == 4'hc |=> q == {8'h00, TEN_MILLISECOND_COUNT_COUNT}; endproperty
   a_cal: assert property (p_cal) else $error("bad calibration");
   property p_unm; tk && a[1:0] != 2'h0 |=> q == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_top; tk && (a == 4'h4 || a == 4'h8) |=> q[31:24] == 8'h00; endproperty
   a_top: assert property (p_top) else $error("upper bits set");
   property p_ctl; tk && a == 4'h0 |=> q[31:17] == 15'h0 && q[15:3] == 13'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("reserved bits set");
   property p_pls; ex |=> !ex; endproperty
   a_pls: assert property (p_pls) else $error("long request");
   property p_hld; DEBUG_HALT_I || !CORE_CLK_RUN_I |=> !ex; endproperty
   a_hld: assert property (p_hld) else $error("request while held");
   c_cal: cover property (tk && a == 4'hc);
   c_exc: cover property (ex);
   c_hld: cover property (DEBUG_HALT_I);
endmodule
bind stk_timer stk_timer_props #(.TEN_MILLISECOND_COUNT_COUNT(TEN_MILLISECOND_COUNT_COUNT)) i_props (
   .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .DEBUG_HALT_I(DEBUG_HALT_I),
   .CORE_CLK_RUN_I(CORE_CLK_RUN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .TICK_EXC_REQ_O(TICK_EXC_REQ_O));
`default_nettype wire

/* File: bench/test_system_tick_down_counter.sv */
// Self-checking bench of the system tick timer
// Drives every timer port itself; the checker is bound to the timer
`timescale 1ns/1ps
`default_nettype none
module test_system_tick_down_counter;
   logic        clk = 0;
   logic        rst_n = 0;
   logic        halt = 0;
   logic        run = 1;
   logic        rd = 0;
   logic        wr = 0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [31:0] got;
   logic        wt;
   logic        exc;
   int          num_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n;
   always #2.5 clk = ~clk;
   stk_timer i_dut (.SYS_CLK_I(clk), .RSTN_I(rst_n), .DEBUG_HALT_I(halt),
      .CORE_CLK_RUN_I(run), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(q),
      .AVS_WAITREQUEST_O(wt), .TICK_EXC_REQ_O(exc));
   // Whole words only, at any address given; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wt !== 1'b0);
      got = q;
      rd <= 0;
      wr <= 0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk($sformatf("reg %h", a), e, got);
   endtask
   task automatic gap();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (exc !== 1'b1 && n < 300);
   endtask
   task automatic quiet(input int k);
      n = 0;
      repeat (k) begin
         @(posedge clk);
         n += (exc === 1'b1);
      end
   endtask
   task automatic t_regs();
      rdc(4'h0, 32'h0);
      rdc(4'h4, 32'h0);
      rdc(4'h8, 32'h0);
      rdc(4'hc, 32'h00002328);
      bus(1, 4'h4, 32'hffffffff);
      rdc(4'h4, 32'h00ffffff);
      bus(1, 4'h2, 32'hffffffff);
      rdc(4'h2, 32'h0);
   endtask
   task automatic t_period(input logic [31:0] ld, input logic [31:0] ct, input int p);
      bus(1, 4'h4, ld);
      bus(1, 4'h0, ct);
      gap();
      gap();
      chk("period", 32'(p), 32'(n));
      bus(1, 4'h0, 32'h0);
   endtask
   task automatic t_stop();
      bus(0, 4'h8, 0);
      rdc(4'h8, got);
      bus(1, 4'h8, 32'h5a);
      rdc(4'h8, 32'h0);
      rdc(4'h0, 32'h0);
   endtask
   task automatic t_shot();
      bus(1, 4'h4, 32'h5);
      bus(1, 4'h0, 32'h7);
      gap();
      chk("delay", 32'h5, 32'(n));
      bus(1, 4'h0, 32'h0);
   endtask
   task automatic t_flag();
      bus(1, 4'h4, 32'h1);
      bus(1, 4'h0, 32'h5);
      quiet(20);
      chk("requests", 32'h0, 32'(n));
      bus(1, 4'h0, 32'h0);
      rdc(4'h0, 32'h00010000);
      rdc(4'h0, 32'h0);
      // Live count drops by three between back-to-back reads
      bus(1, 4'h4, 32'h100);
      bus(1, 4'h0, 32'h5);
      bus(0, 4'h8, 0);
      rdc(4'h8, got - 32'd3);
   endtask
   task automatic t_hold();
      bus(1, 4'h4, 32'h3);
      bus(1, 4'h8, 32'h0);
      bus(1, 4'h0, 32'h7);
      for (int i = 0; i < 2; i++) begin
         halt <= (i == 0);
         run <= (i == 0);
         bus(0, 4'h8, 0);
         quiet(20);
         chk("held requests", 32'h0, 32'(n));
         rdc(4'h8, got);
      end
      halt <= 0;
      run <= 1;
      bus(1, 4'h4, 32'h0);
      bus(1, 4'h8, 32'h0);
      // A last 1 to 0 step may coincide with the clearing write; read it away
      bus(0, 4'h0, 0);
      quiet(40);
      chk("zero reload", 32'h0, 32'(n));
      rdc(4'h0, 32'h7);
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_period(32'h3, 32'h7, 4);
      t_stop();
      t_shot();
      t_period(32'h2, 32'h3, 24);
      t_flag();
      t_hold();
      report_and_stop();
   end
endmodule
`default_nettype wire
